/* src/bps_power_sequencer.sv */
// Purpose: power-up sequencing, hibernate, supply and thermal supervision
// Assumes: comparator inputs are asynchronous levels, firmware inputs on i_mclk
// Notes: all enables and flags are registered
// Contract
// - enable buck once input reaches start level
// - main rail at 10 V, 4 ms, system rail
// - system rail good, 0.5 ms, io rail
// - io rail, 0.5 ms, analog rail
// - analog rail, 1 ms, flash and core
// - core rail, 0.5 ms, sample all power-good
// - all good, 1 ms, release processor reset
// - charge pump follows firmware enable, only while running
// - firmware request starts hibernate entry
// - hibernate turns off regulators, keeps wake detect
// - wake button with selectable polarity ends hibernate
// - charger detect at 5 or 20 V wakes
// - wake timer wakes; sources individually selectable
// - system, io, analog or core power-good drop flags fault, resets processor
// - reset held until five rails good plus delay
// - monitor multiplexer selects one of eight sources
// - 120 and 140 C warnings without reset
// - per-threshold temperature interrupt enables
// - 155 C records fault and resets processor
// - temperature fault bits survive processor reset
// - main rail lockout: buck off, restart 350 ms
// - input lockout: restart once input rises again
`timescale 1ns/100ps
module bps_power_sequencer
   import bps_pkg::*;
#(
   parameter int unsigned P_SYS_DLY_CYC = SYS_DLY_CYC,
   parameter int unsigned P_IO_DLY_CYC = IO_DLY_CYC,
   parameter int unsigned P_ANA_DLY_CYC = ANA_DLY_CYC,
   parameter int unsigned P_FC_DLY_CYC = FC_DLY_CYC,
   parameter int unsigned P_CHK_DLY_CYC = CHK_DLY_CYC,
   parameter int unsigned P_REL_DLY_CYC = REL_DLY_CYC,
   parameter int unsigned P_RESTART_DLY_CYC = RESTART_DLY_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // supply comparators
   input wire logic i_vin_start,
   input wire logic i_vin_above_fall,
   input wire logic i_main_rail_10v,
   input wire logic i_main_rail_above_fall,
   input wire logic i_sys_pgood,
   input wire logic i_io_pgood,
   input wire logic i_analog_pgood,
   input wire logic i_flash_pgood,
   input wire logic i_core_pgood,
   // temperature comparators
   input wire logic i_temp_120,
   input wire logic i_temp_140,
   input wire logic i_temp_155,
   // wake sources
   input wire logic i_wake_button_pin,
   input wire logic i_charger_5v,
   input wire logic i_charger_20v,
   input wire logic i_wake_timer_expired,
   // firmware controls
   input wire logic i_pump_enable,
   input wire logic i_hibernate_req,
   input wire logic [2:0] i_wake_sel,
   input wire logic i_button_active_high,
   input wire logic i_charger_sel_20v,
   input wire logic [2:0] i_temp_irq_en,
   input wire logic [2:0] i_mux_sel,
   input wire logic i_status_clear,
   // regulator enables
   output logic o_main_buck_converter_en,
   output logic o_sys_rail_en,
   output logic o_io_rail_en,
   output logic o_analog_rail_en,
   output logic o_flash_rail_en,
   output logic o_core_rail_en,
   output logic o_gate_charge_pump_en,
   // processor and hibernate
   output logic o_cpu_reset_n,
   output logic o_hibernate,
   output logic o_wake_detect_en,
   // status
   output logic o_supply_fault,
   output logic [2:0] o_temp_flags,
   output logic o_temp_irq,
   output logic [2:0] o_monitor_multiplexer_sel
);

   bps_state_type state;
   bps_state_type next_state;
   logic [SY_N-1:0] sy;
   logic [TMR_W-1:0] timer;
   logic timer_done;
   logic all_pg;
   logic rail_drop;
   logic button_active;
   logic charger_det;
   logic wake;

   // comparator synchronisers
   bps_sync #(
      .WIDTH(SY_N)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_async({i_wake_timer_expired, i_charger_20v, i_charger_5v, i_wake_button_pin,
                i_temp_155, i_temp_140, i_temp_120, i_core_pgood, i_flash_pgood,
                i_analog_pgood, i_io_pgood, i_sys_pgood, i_main_rail_above_fall,
                i_main_rail_10v, i_vin_above_fall, i_vin_start}),
      .o_sync(sy)
   );

   // states in which the main rail is up and supervised
   function automatic logic is_powered(input bps_state_type s);
      return !(s inside {ST_OFF, ST_BUCK, ST_RESTART, ST_HIB});
   endfunction : is_powered

   // delay loaded on entry to each timed state
   function automatic logic [TMR_W-1:0] dly_of(input bps_state_type s);
      logic [TMR_W-1:0] d;
      d = '0;
      case (s)
         ST_WAIT_SYS: d = TMR_W'(P_SYS_DLY_CYC - 1);
         ST_WAIT_IO: d = TMR_W'(P_IO_DLY_CYC - 1);
         ST_IO_UP: d = TMR_W'(P_ANA_DLY_CYC - 1);
         ST_ANA_UP: d = TMR_W'(P_FC_DLY_CYC - 1);
         ST_FC_UP: d = TMR_W'(P_CHK_DLY_CYC - 1);
         ST_RELEASE: d = TMR_W'(P_REL_DLY_CYC - 1);
         ST_RESTART: d = TMR_W'(P_RESTART_DLY_CYC - 1);
         default: d = '0;
      endcase
      return d;
   endfunction : dly_of

   assign all_pg = sy[SY_SYS_PG] & sy[SY_IO_PG] & sy[SY_ANA_PG] & sy[SY_FLASH_PG]
                   & sy[SY_CORE_PG];
   assign rail_drop = !(sy[SY_SYS_PG] & sy[SY_IO_PG] & sy[SY_ANA_PG] & sy[SY_CORE_PG]);
   assign timer_done = (timer == '0);

   // wake qualification
   assign button_active = sy[SY_BUTTON] ~^ i_button_active_high;
   assign charger_det = i_charger_sel_20v ? sy[SY_CHG_20V] : sy[SY_CHG_5V];
   assign wake = (i_wake_sel[WK_BUTTON] & button_active)
                 | (i_wake_sel[WK_CHARGER] & charger_det)
                 | (i_wake_sel[WK_TIMER] & sy[SY_WAKE_TMR]);

   // sequencer next state
   always_comb begin
      next_state = state;
      if (is_powered(state) && !sy[SY_VIN_OK]) begin
         next_state = ST_OFF;
      end else if (is_powered(state) && !sy[SY_VP_OK]) begin
         next_state = ST_RESTART;
      end else begin
         unique case (state)
            ST_OFF: begin
               if (sy[SY_VIN_START]) begin
                  next_state = ST_BUCK;
               end
            end
            ST_BUCK: begin
               if (!sy[SY_VIN_OK]) begin
                  next_state = ST_OFF;
               end else if (sy[SY_VP_10V]) begin
                  next_state = ST_WAIT_SYS;
               end
            end
            ST_RESTART: begin
               if (!sy[SY_VIN_OK]) begin
                  next_state = ST_OFF;
               end else if (timer_done) begin
                  next_state = ST_BUCK;
               end
            end
            ST_WAIT_SYS: begin
               if (timer_done) begin
                  next_state = ST_SYS_UP;
               end
            end
            ST_SYS_UP: begin
               if (sy[SY_SYS_PG]) begin
                  next_state = ST_WAIT_IO;
               end
            end
            ST_WAIT_IO: begin
               if (timer_done) begin
                  next_state = ST_IO_UP;
               end
            end
            ST_IO_UP: begin
               if (timer_done) begin
                  next_state = ST_ANA_UP;
               end
            end
            ST_ANA_UP: begin
               if (timer_done) begin
                  next_state = ST_FC_UP;
               end
            end
            ST_FC_UP: begin
               if (timer_done) begin
                  next_state = all_pg ? ST_RELEASE : ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (all_pg && !sy[SY_T155]) begin
                  next_state = ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               if (!all_pg || sy[SY_T155]) begin
                  next_state = ST_HOLD;
               end else if (timer_done) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (rail_drop || sy[SY_T155]) begin
                  next_state = ST_HOLD;
               end else if (i_hibernate_req) begin
                  next_state = ST_HIB;
               end
            end
            ST_HIB: begin
               if (wake) begin
                  next_state = ST_OFF;
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // delay counter
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         timer <= '0;
      end else if (next_state != state) begin
         timer <= dly_of(next_state);
      end else if (!timer_done) begin
         timer <= timer - TMR_W'(1);
      end
   end

   // regulator and processor controls, decoded from the next state
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_main_buck_converter_en <= 1'b0;
         o_sys_rail_en <= 1'b0;
         o_io_rail_en <= 1'b0;
         o_analog_rail_en <= 1'b0;
         o_flash_rail_en <= 1'b0;
         o_core_rail_en <= 1'b0;
         o_cpu_reset_n <= 1'b0;
         o_hibernate <= 1'b0;
         o_wake_detect_en <= 1'b0;
      end else begin
         o_main_buck_converter_en <= !(next_state inside {ST_OFF, ST_RESTART, ST_HIB});
         o_sys_rail_en <= is_powered(next_state) && next_state != ST_WAIT_SYS;
         o_io_rail_en <= next_state inside {ST_IO_UP, ST_ANA_UP, ST_FC_UP, ST_HOLD,
                                            ST_RELEASE, ST_RUN};
         o_analog_rail_en <= next_state inside {ST_ANA_UP, ST_FC_UP, ST_HOLD,
                                                ST_RELEASE, ST_RUN};
         o_flash_rail_en <= next_state inside {ST_FC_UP, ST_HOLD, ST_RELEASE, ST_RUN};
         o_core_rail_en <= next_state inside {ST_FC_UP, ST_HOLD, ST_RELEASE, ST_RUN};
         o_cpu_reset_n <= (next_state == ST_RUN);
         o_hibernate <= (next_state == ST_HIB);
         o_wake_detect_en <= (next_state == ST_HIB);
      end
   end

   // gate charge pump, firmware controlled while running
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_gate_charge_pump_en <= 1'b0;
      end else begin
         o_gate_charge_pump_en <= i_pump_enable && (next_state == ST_RUN);
      end
   end

   // sticky supply fault, set wins over clear
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_supply_fault <= 1'b0;
      end else if (state == ST_RUN && rail_drop) begin
         o_supply_fault <= 1'b1;
      end else if (i_status_clear) begin
         o_supply_fault <= 1'b0;
      end
   end

   // sticky temperature flags, kept through processor reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_temp_flags <= '0;
      end else begin
         o_temp_flags <= {sy[SY_T155], sy[SY_T140], sy[SY_T120]}
                         | (o_temp_flags & {3{!i_status_clear}});
      end
   end

   // temperature interrupt
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_temp_irq <= 1'b0;
      end else begin
         o_temp_irq <= |(o_temp_flags & i_temp_irq_en);
      end
   end

   // monitor multiplexer select
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_monitor_multiplexer_sel <= MUX_CHARGER_TERM;
      end else begin
         o_monitor_multiplexer_sel <= i_mux_sel;
      end
   end

   // checks
   buck_start_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state == ST_OFF && sy[SY_VIN_START]) |=> ##1 o_main_buck_converter_en)
      else $error("buck not enabled after start level");

   sys_delay_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_sys_rail_en) |-> $past(state, 2) == ST_WAIT_SYS)
      else $error("system rail enabled outside its delay");

   io_order_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_io_rail_en |-> o_sys_rail_en)
      else $error("io rail on without system rail");

   ana_order_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_analog_rail_en |-> o_io_rail_en)
      else $error("analog rail on before io rail");

   flash_core_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_flash_rail_en == o_core_rail_en && (o_core_rail_en -> o_analog_rail_en))
      else $error("flash and core rails not together");

   release_good_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_cpu_reset_n) |-> $past(state, 2) == ST_RELEASE && $past(all_pg, 2))
      else $error("processor released without good rails");

   rail_fault_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state == ST_RUN && rail_drop) |=> o_supply_fault ##1 !o_cpu_reset_n)
      else $error("rail drop did not reset processor");

   hib_off_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_hibernate |-> !o_sys_rail_en && !o_core_rail_en && !o_main_buck_converter_en
                      && o_wake_detect_en && !o_cpu_reset_n)
      else $error("regulator on during hibernate");

   wake_restart_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state == ST_HIB && wake) |=> state == ST_OFF)
      else $error("wake did not restart sequence");

   temp_fault_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state == ST_RUN && sy[SY_T155]) |=> o_temp_flags[TF_155] ##1 !o_cpu_reset_n)
      else $error("temperature fault not handled");

   temp_keep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (o_temp_flags[TF_155] && !i_status_clear) |=> o_temp_flags[TF_155])
      else $error("temperature fault lost");

   warn_noreset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state == ST_RUN && sy[SY_T140] && !sy[SY_T155] && !rail_drop && sy[SY_VIN_OK]
       && sy[SY_VP_OK] && !i_hibernate_req) |=> state == ST_RUN)
      else $error("warning reset the processor");

   restart_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (is_powered(state) && sy[SY_VIN_OK] && !sy[SY_VP_OK]) |=> state == ST_RESTART
      ##1 !o_main_buck_converter_en)
      else $error("main rail lockout missed");

   pump_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_gate_charge_pump_en |-> o_cpu_reset_n)
      else $error("charge pump on while not running");

   run_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_cpu_reset_n));
   hib_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_hibernate ##1 !o_hibernate);
   restart_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      state == ST_RESTART ##1 state == ST_BUCK);
   tfault_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_temp_flags[TF_155]));

endmodule : bps_power_sequencer

/* src/bps_pkg.sv */
// Purpose: shared constants and types for the power sequencer
// Assumes: 20 MHz always-on timebase
// Notes: times in microseconds, cycle counts derived from the clock rate
package bps_pkg;

   // timebase
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

   // sequencing times in microseconds
   localparam int unsigned T_SYS_US = 4000;
   localparam int unsigned T_IO_US = 500;
   localparam int unsigned T_ANA_US = 500;
   localparam int unsigned T_FC_US = 1000;
   localparam int unsigned T_CHK_US = 500;
   localparam int unsigned T_REL_US = 1000;
   localparam int unsigned T_RESTART_US = 350000;

   // sequencing times in clock cycles
   localparam int unsigned SYS_DLY_CYC = T_SYS_US * CLK_MHZ;
   localparam int unsigned IO_DLY_CYC = T_IO_US * CLK_MHZ;
   localparam int unsigned ANA_DLY_CYC = T_ANA_US * CLK_MHZ;
   localparam int unsigned FC_DLY_CYC = T_FC_US * CLK_MHZ;
   localparam int unsigned CHK_DLY_CYC = T_CHK_US * CLK_MHZ;
   localparam int unsigned REL_DLY_CYC = T_REL_US * CLK_MHZ;
   localparam int unsigned RESTART_DLY_CYC = T_RESTART_US * CLK_MHZ;

   // delay counter width, holds the longest count
   localparam int unsigned TMR_W = 23;

   // synchroniser lanes
   localparam int unsigned SY_VIN_START = 0;
   localparam int unsigned SY_VIN_OK = 1;
   localparam int unsigned SY_VP_10V = 2;
   localparam int unsigned SY_VP_OK = 3;
   localparam int unsigned SY_SYS_PG = 4;
   localparam int unsigned SY_IO_PG = 5;
   localparam int unsigned SY_ANA_PG = 6;
   localparam int unsigned SY_FLASH_PG = 7;
   localparam int unsigned SY_CORE_PG = 8;
   localparam int unsigned SY_T120 = 9;
   localparam int unsigned SY_T140 = 10;
   localparam int unsigned SY_T155 = 11;
   localparam int unsigned SY_BUTTON = 12;
   localparam int unsigned SY_CHG_5V = 13;
   localparam int unsigned SY_CHG_20V = 14;
   localparam int unsigned SY_WAKE_TMR = 15;
   localparam int unsigned SY_N = 16;

   // wake source select bits
   localparam int unsigned WK_BUTTON = 0;
   localparam int unsigned WK_CHARGER = 1;
   localparam int unsigned WK_TIMER = 2;

   // temperature flag bits
   localparam int unsigned TF_120 = 0;
   localparam int unsigned TF_140 = 1;
   localparam int unsigned TF_155 = 2;

   // monitor multiplexer sources
   localparam logic [2:0] MUX_CHARGER_TERM = 3'h0;
   localparam logic [2:0] MUX_BATTERY_STACK = 3'h1;
   localparam logic [2:0] MUX_INPUT_SUPPLY = 3'h2;
   localparam logic [2:0] MUX_CORE_RAIL = 3'h3;
   localparam logic [2:0] MUX_ANALOG_RAIL = 3'h4;
   localparam logic [2:0] MUX_IO_RAIL = 3'h5;
   localparam logic [2:0] MUX_SYS_RAIL = 3'h6;
   localparam logic [2:0] MUX_TEMP_SENSE = 3'h7;

   // sequencer states
   typedef enum logic [3:0] {
      ST_OFF,
      ST_BUCK,
      ST_RESTART,
      ST_WAIT_SYS,
      ST_SYS_UP,
      ST_WAIT_IO,
      ST_IO_UP,
      ST_ANA_UP,
      ST_FC_UP,
      ST_HOLD,
      ST_RELEASE,
      ST_RUN,
      ST_HIB
   } bps_state_type;

endpackage : bps_pkg

/* src/bps_sync.sv */
// Purpose: two-flop synchroniser for a vector of levels
// Assumes: each lane is an independent slow level
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module bps_sync #(
   parameter int unsigned WIDTH = 16
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end

endmodule : bps_sync

/* test/bps_fw_model.sv */
// Purpose: firmware stand-in for the charge pump and hibernate controls
// Assumes: firmware code runs only while the processor reset is released
// Notes: bench commands reach the ports at the falling edge
`timescale 1ns/100ps
module bps_fw_model (
   // clock and processor reset
   input wire logic i_mclk,
   input wire logic i_cpu_reset_n,
   // bench commands
   input wire logic i_cmd_pump,
   input wire logic i_cmd_hib,
   // firmware controls
   output logic o_pump_enable,
   output logic o_hibernate_req
);
   // controls only move while code runs
   always @(negedge i_mclk) begin
      o_pump_enable <= i_cmd_pump & i_cpu_reset_n;
      o_hibernate_req <= i_cmd_hib & i_cpu_reset_n;
   end
endmodule : bps_fw_model

/* test/test_bms_power_sequencer.sv */
// Purpose: self-checking bench for the power sequencer
// Assumes: rails follow their enables, firmware model drives pump and hibernate
// Notes: short delay parameters keep the run small
`timescale 1ns/100ps
module test_bms_power_sequencer;
   import bps_pkg::*;
   localparam int P_SYS = 8, P_IO = 4, P_ANA = 5, P_FC = 6, P_CHK = 4, P_REL = 7, P_RST = 9;
   logic i_mclk, i_rst_n, i_vin_start, i_vin_above_fall, i_main_rail_10v, i_main_rail_above_fall;
   logic i_sys_pgood, i_io_pgood, i_analog_pgood, i_flash_pgood, i_core_pgood;
   logic i_temp_120, i_temp_140, i_temp_155, i_wake_button_pin, i_charger_5v, i_charger_20v;
   logic i_wake_timer_expired, i_pump_enable, i_hibernate_req, i_button_active_high;
   logic i_charger_sel_20v, i_status_clear, cmd_pump, cmd_hib;
   logic [2:0] i_wake_sel, i_temp_irq_en, i_mux_sel, o_temp_flags, o_monitor_multiplexer_sel;
   logic o_main_buck_converter_en, o_sys_rail_en, o_io_rail_en, o_analog_rail_en;
   logic o_flash_rail_en, o_core_rail_en, o_gate_charge_pump_en, o_cpu_reset_n;
   logic o_hibernate, o_wake_detect_en, o_supply_fault, o_temp_irq;
   logic [4:0] pg_drop;
   logic [31:0] seed = 32'hac2c;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int t0, t1;
   wire [7:0] mon = {o_hibernate, o_cpu_reset_n, o_core_rail_en, o_flash_rail_en,
      o_analog_rail_en, o_io_rail_en, o_sys_rail_en, o_main_buck_converter_en};

   bps_power_sequencer #(.P_SYS_DLY_CYC(P_SYS), .P_IO_DLY_CYC(P_IO), .P_ANA_DLY_CYC(P_ANA),
      .P_FC_DLY_CYC(P_FC), .P_CHK_DLY_CYC(P_CHK), .P_REL_DLY_CYC(P_REL),
      .P_RESTART_DLY_CYC(P_RST)) dut (.i_mclk, .i_rst_n, .i_vin_start, .i_vin_above_fall,
      .i_main_rail_10v, .i_main_rail_above_fall, .i_sys_pgood, .i_io_pgood, .i_analog_pgood,
      .i_flash_pgood, .i_core_pgood, .i_temp_120, .i_temp_140, .i_temp_155,
      .i_wake_button_pin, .i_charger_5v, .i_charger_20v, .i_wake_timer_expired,
      .i_pump_enable, .i_hibernate_req, .i_wake_sel, .i_button_active_high,
      .i_charger_sel_20v, .i_temp_irq_en, .i_mux_sel, .i_status_clear,
      .o_main_buck_converter_en, .o_sys_rail_en, .o_io_rail_en, .o_analog_rail_en,
      .o_flash_rail_en, .o_core_rail_en, .o_gate_charge_pump_en, .o_cpu_reset_n,
      .o_hibernate, .o_wake_detect_en, .o_supply_fault, .o_temp_flags, .o_temp_irq,
      .o_monitor_multiplexer_sel);

   bps_fw_model fw (.i_mclk(i_mclk), .i_cpu_reset_n(o_cpu_reset_n), .i_cmd_pump(cmd_pump),
      .i_cmd_hib(cmd_hib), .o_pump_enable(i_pump_enable), .o_hibernate_req(i_hibernate_req));

   initial i_mclk = 1'b0;
   always #25 i_mclk = ~i_mclk;
   always @(posedge i_mclk) cyc <= cyc + 1;

   // rails follow their enables, less any forced drop
   always @(negedge i_mclk) begin
      i_main_rail_10v <= o_main_buck_converter_en;
      i_sys_pgood <= o_sys_rail_en & ~pg_drop[0];
      i_io_pgood <= o_io_rail_en & ~pg_drop[1];
      i_analog_pgood <= o_analog_rail_en & ~pg_drop[2];
      i_flash_pgood <= o_flash_rail_en & ~pg_drop[3];
      i_core_pgood <= o_core_rail_en & ~pg_drop[4];
   end

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function logic exp_irq(logic [2:0] f, logic [2:0] en);
      return |(f & en);
   endfunction : exp_irq

   task chk(logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task test_done();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done

   task wait_for(int k, logic v, output int t);
      for (int n = 0; n < 400; n++) begin
         if (mon[k] === v) begin
            t = cyc;
            return;
         end
         @(negedge i_mclk);
      end
      err_count++;
      test_done();
   endtask : wait_for

   task power_up();
      int b, s, io, an, fl, rs;
      wait_for(0, 1'b1, b);
      wait_for(1, 1'b1, s);
      wait_for(2, 1'b1, io);
      wait_for(3, 1'b1, an);
      wait_for(4, 1'b1, fl);
      chk(o_core_rail_en, 1);
      wait_for(6, 1'b1, rs);
      chk(s - b >= P_SYS, 1);
      chk(io - s >= P_IO, 1);
      chk(an - io, P_ANA);
      chk(fl - an, P_FC);
      chk(rs - fl, P_CHK + P_REL);
   endtask : power_up

   task clr();
      i_status_clear = 1'b1;
      @(negedge i_mclk);
      i_status_clear = 1'b0;
      repeat (2) @(negedge i_mclk);
      chk({o_supply_fault, o_temp_flags}, 0);
   endtask : clr

   initial begin
      {i_rst_n, i_vin_start, i_vin_above_fall, i_main_rail_above_fall} = '0;
      {i_temp_120, i_temp_140, i_temp_155, i_wake_button_pin, i_charger_5v, i_charger_20v} = '0;
      {i_wake_timer_expired, i_button_active_high, i_charger_sel_20v, i_status_clear} = '0;
      {cmd_pump, cmd_hib, i_wake_sel, i_temp_irq_en, i_mux_sel, pg_drop} = '0;
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
      {i_rst_n, i_vin_start, i_vin_above_fall, i_main_rail_above_fall} = 4'hf;
      power_up();
      // every mux source, then random picks
      for (int k = 0; k < 12; k++) begin
         i_mux_sel = (k < 8) ? 3'(k) : 3'(xs());
         @(negedge i_mclk);
         chk(o_monitor_multiplexer_sel, i_mux_sel);
      end
      cmd_pump <= 1'b1;
      repeat (3) @(negedge i_mclk);
      chk(o_gate_charge_pump_en, 1);
      cmd_pump <= 1'b0;
      repeat (3) @(negedge i_mclk);
      chk(o_gate_charge_pump_en, 0);
      // thermal warnings, masking, fault
      i_temp_irq_en = 3'h1;
      i_temp_120 = 1'b1;
      repeat (6) @(negedge i_mclk);
      chk({o_temp_flags, o_temp_irq}, {3'h1, exp_irq(3'h1, i_temp_irq_en)});
      i_temp_140 = 1'b1;
      i_temp_irq_en = 3'h4;
      repeat (6) @(negedge i_mclk);
      chk({o_cpu_reset_n, o_temp_flags}, {1'b1, 3'h3});
      chk(o_temp_irq, exp_irq(3'h3, i_temp_irq_en));
      i_temp_155 = 1'b1;
      wait_for(6, 1'b0, t0);
      repeat (3) @(negedge i_mclk);
      chk({o_temp_flags, o_temp_irq}, {3'h7, exp_irq(3'h7, i_temp_irq_en)});
      {i_temp_120, i_temp_140, i_temp_155} = 3'h0;
      wait_for(6, 1'b1, t1);
      chk(o_temp_flags, 3'h7);
      clr();
      // rail drops, flash rail holding release
      for (int k = 0; k < 5; k++) begin
         if (k == 3) continue;
         pg_drop <= 5'(1 << k);
         wait_for(6, 1'b0, t0);
         chk(o_supply_fault, 1);
         pg_drop <= 5'h08;
         repeat (30) @(negedge i_mclk);
         chk(o_cpu_reset_n, 0);
         pg_drop <= 5'h00;
         t0 = cyc;
         wait_for(6, 1'b1, t1);
         chk(t1 - t0, P_REL + 4);
         clr();
      end
      // hibernate entry and each wake source
      for (int k = 0; k < 6; k++) begin
         int w;
         w = k % 3;
         i_button_active_high = 1'(k / 3) ^ seed[1];
         i_charger_sel_20v = 1'(k / 3) ^ seed[0];
         i_wake_button_pin = ~i_button_active_high;
         i_charger_5v = i_charger_sel_20v;
         i_wake_sel = 3'h7 ^ 3'(1 << w);
         cmd_hib <= 1'b1;
         wait_for(7, 1'b1, t0);
         cmd_hib <= 1'b0;
         chk({mon[6:0], o_gate_charge_pump_en, o_wake_detect_en}, 9'h001);
         if (w == 0) i_wake_button_pin = i_button_active_high;
         if (w == 1) {i_charger_20v, i_charger_5v} = {i_charger_sel_20v, 1'b1};
         if (w == 2) i_wake_timer_expired = 1'b1;
         repeat (10) @(negedge i_mclk);
         chk(o_hibernate, 1);
         i_wake_sel = 3'(1 << w);
         wait_for(7, 1'b0, t0);
         {i_wake_button_pin, i_charger_5v, i_charger_20v} = {~i_button_active_high, 2'h0};
         i_wake_timer_expired = 1'b0;
         power_up();
      end
      // main rail lockout restart, then input lockout
      i_main_rail_above_fall = 1'b0;
      wait_for(0, 1'b0, t0);
      i_main_rail_above_fall = 1'b1;
      wait_for(0, 1'b1, t1);
      chk(t1 - t0, P_RST);
      power_up();
      {i_vin_above_fall, i_vin_start} = 2'b00;
      wait_for(0, 1'b0, t0);
      i_vin_above_fall = 1'b1;
      repeat (10) @(negedge i_mclk);
      chk(o_main_buck_converter_en, 0);
      i_vin_start = 1'b1;
      power_up();
      test_done();
   end
endmodule : test_bms_power_sequencer
